/* pkg/fsp_pkg.sv */
// package for the flash status poll and protect host controller
package fsp_pkg;
   // ---------------------------------------------------------------
   // register map of the controller
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h1;
   localparam logic [3:0] REG_DATA = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam logic [3:0] REG_IRQ_STATUS = 4'h4;
   localparam logic [3:0] REG_IRQ_MASK = 4'h5;
   localparam logic [3:0] REG_RDATA = 4'h6;
   // ctrl command codes, written into bits 2:0
   localparam logic [2:0] CMD_WRITE = 3'h1;
   localparam logic [2:0] CMD_READ = 3'h2;
   localparam logic [2:0] CMD_POLL = 3'h3;
   localparam logic [2:0] CMD_TOGGLE = 3'h4;
   localparam logic [2:0] CMD_PROTECT = 3'h5;
   localparam logic [2:0] CMD_UNPROTECT = 3'h6;
   localparam logic [2:0] CMD_TEMP = 3'h7;
   localparam int CTRL_TEMP_EXIT_BIT = 3;
   // irq bits
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_FAIL_BIT = 1;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   // data status bit positions
   localparam int POLL_BIT = 7;
   localparam int TOGGLE_BIT = 6;
   localparam int TIMEOUT_BIT = 5;
   // address bits for protect selection
   localparam int ADDR_SIX = 6;
   localparam int ADDR_ONE = 1;
   localparam int ADDR_ZERO = 0;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 25;
   localparam int VOLT_SETUP_US = 4;
   localparam int VOLT_SETUP_CYC = VOLT_SETUP_US * CLK_MHZ;
   localparam int PROT_PULSE_NS = 100;
   localparam int PROT_PULSE_CYC = (PROT_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int STROBE_CYC = 3;
   localparam int PROG_TYP_US = 11;
   localparam int PROG_TYP_CYC = PROG_TYP_US * CLK_MHZ;
   // erase 1.6 s, in ms to stay integer
   localparam int ERASE_TYP_MS = 1600;
   localparam int ERASE_TYP_CYC = ERASE_TYP_MS * CLK_MHZ * 1000;
   localparam logic [7:0] CMD_PROTECT_DATA = 8'h60;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_WR = 4'h1,
      ST_RD = 4'h2,
      ST_RD_GAP = 4'h3,
      ST_VSETUP = 4'h4,
      ST_PPULSE = 4'h5,
      ST_TEMP = 4'h6,
      ST_TEMP_HOLD = 4'h7,
      ST_DONE = 4'h8
   } fsp_state_e;

   typedef struct packed {
      logic ceN;
      logic oeN;
      logic weN;
      logic rstN;
      logic highVolt;
      logic [21:0] addr;
      logic [15:0] dOut;
      logic dOe;
   } fsp_pins_s;
endpackage : fsp_pkg

/* verilog/fsp_host.sv */
// host controller: strobes, status polling and protect sequences
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/10ps
module fsp_host #(
   parameter int VSETUP_CYC = fsp_pkg::VOLT_SETUP_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // register port
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   output logic irq,
   // flash pins
   output fsp_pkg::fsp_pins_s flashPins,
   input wire logic [15:0] flashDin,
   input wire logic readyBusy
);
   typedef struct packed {
      fsp_pkg::fsp_state_e st;
      fsp_pkg::fsp_pins_s pins;
      logic [2:0] cmd;
      logic [21:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic [15:0] prevRd;
      logic [1:0] rdCount;
      logic timeoutSeen;
      logic busy;
      logic fail;
      logic tempExit;
      logic [1:0] irqStat;
      logic [1:0] irqMask;
      logic [31:0] rdOut;
      logic irqOut;
      logic [15:0] cnt;
   } fsp_state_s;

   fsp_state_s r;
   fsp_state_s next_r;

   always_comb begin
      logic [1:0] ev;
      logic tog;
      ev = 2'h0;
      tog = 1'b0;
      next_r = r;
      // ---------------------------------------------------------------
      // sequencer
      // ---------------------------------------------------------------
      case (r.st)
         fsp_pkg::ST_IDLE: begin
            next_r.pins.ceN = 1'b1;
            next_r.pins.oeN = 1'b1;
            next_r.pins.weN = 1'b1;
            next_r.pins.dOe = 1'b0;
            if (r.busy) begin
               next_r.pins.addr = r.addr;
               next_r.cnt = 16'h0;
               case (r.cmd)
                  fsp_pkg::CMD_WRITE: begin
                     next_r.pins.ceN = 1'b0;
                     next_r.pins.weN = 1'b0;
                     next_r.pins.dOut = r.wdata;
                     next_r.pins.dOe = 1'b1;
                     next_r.st = fsp_pkg::ST_WR;
                  end
                  fsp_pkg::CMD_READ, fsp_pkg::CMD_POLL, fsp_pkg::CMD_TOGGLE: begin
                     next_r.pins.ceN = 1'b0;
                     next_r.pins.oeN = 1'b0;
                     next_r.st = fsp_pkg::ST_RD;
                  end
                  fsp_pkg::CMD_PROTECT, fsp_pkg::CMD_UNPROTECT: begin
                     next_r.pins.addr[fsp_pkg::ADDR_SIX] =
                        (r.cmd == fsp_pkg::CMD_UNPROTECT);
                     next_r.pins.addr[fsp_pkg::ADDR_ONE] = 1'b1;
                     next_r.pins.addr[fsp_pkg::ADDR_ZERO] = 1'b0;
                     next_r.pins.highVolt = 1'b1;
                     next_r.pins.ceN = 1'b0;
                     next_r.pins.oeN = 1'b1;
                     next_r.pins.dOut = {8'h0, fsp_pkg::CMD_PROTECT_DATA};
                     next_r.st = fsp_pkg::ST_VSETUP;
                  end
                  default: begin
                     next_r.pins.highVolt = 1'b1;
                     next_r.st = fsp_pkg::ST_TEMP;
                  end
               endcase
            end
         end
         fsp_pkg::ST_WR: begin
            next_r.cnt = r.cnt + 16'h1;
            if (r.cnt == 16'(fsp_pkg::STROBE_CYC - 1)) begin
               next_r.pins.weN = 1'b1;
               next_r.st = fsp_pkg::ST_DONE;
            end
         end
         fsp_pkg::ST_RD: begin
            next_r.cnt = r.cnt + 16'h1;
            if (r.cnt == 16'(fsp_pkg::STROBE_CYC - 1)) begin
               next_r.pins.oeN = 1'b1;
               next_r.pins.ceN = 1'b1;
               next_r.rdata = flashDin;
               next_r.prevRd = r.rdata;
               next_r.rdCount = r.rdCount + 2'h1;
               next_r.st = fsp_pkg::ST_RD_GAP;
            end
         end
         fsp_pkg::ST_RD_GAP: begin
            next_r.cnt = 16'h0;
            tog = r.rdata[fsp_pkg::TOGGLE_BIT] ^ r.prevRd[fsp_pkg::TOGGLE_BIT];
            next_r.st = fsp_pkg::ST_DONE;
            if (r.cmd == fsp_pkg::CMD_POLL) begin
               if (r.rdata[fsp_pkg::POLL_BIT] == r.wdata[fsp_pkg::POLL_BIT]) begin
                  next_r.fail = 1'b0;
               end else if (r.timeoutSeen) begin
                  next_r.fail = 1'b1;
               end else begin
                  // poll bit not matched yet: note the timeout flag and read the poll bit again
                  next_r.timeoutSeen = r.rdata[fsp_pkg::TIMEOUT_BIT];
                  next_r.st = fsp_pkg::ST_IDLE;
               end
            end else if (r.cmd == fsp_pkg::CMD_TOGGLE) begin
               if (r.rdCount < 2'h2) begin
                  next_r.st = fsp_pkg::ST_IDLE;
               end else if (!tog) begin
                  next_r.fail = 1'b0;
               end else if (r.timeoutSeen) begin
                  next_r.fail = 1'b1;
               end else if (r.rdata[fsp_pkg::TIMEOUT_BIT]) begin
                  // toggling may stop as the flag rises
                  next_r.timeoutSeen = 1'b1;
                  next_r.rdCount = 2'h1;
                  next_r.st = fsp_pkg::ST_IDLE;
               end else begin
                  next_r.rdCount = 2'h1;
                  next_r.st = fsp_pkg::ST_IDLE;
               end
            end
         end
         fsp_pkg::ST_VSETUP: begin
            next_r.cnt = r.cnt + 16'h1;
            if (r.cnt == 16'(VSETUP_CYC - 1)) begin
               next_r.pins.weN = 1'b0;
               next_r.cnt = 16'h0;
               next_r.st = fsp_pkg::ST_PPULSE;
            end
         end
         fsp_pkg::ST_PPULSE: begin
            next_r.cnt = r.cnt + 16'h1;
            if (r.cnt == 16'(fsp_pkg::PROT_PULSE_CYC - 1)) begin
               next_r.pins.weN = 1'b1;
               next_r.pins.ceN = 1'b1;
               next_r.pins.highVolt = 1'b0;
               next_r.st = fsp_pkg::ST_DONE;
            end
         end
         fsp_pkg::ST_TEMP: begin
            // exit allowed only after the setup span, with tempExit set and the flash ready
            if (r.cnt != 16'(VSETUP_CYC)) begin
               next_r.cnt = r.cnt + 16'h1;
            end else if (r.tempExit && readyBusy) begin
               next_r.cnt = 16'h0;
               next_r.st = fsp_pkg::ST_TEMP_HOLD;
            end
         end
         fsp_pkg::ST_TEMP_HOLD: begin
            next_r.cnt = r.cnt + 16'h1;
            if (!readyBusy) begin
               next_r.cnt = 16'h0;
            end else if (r.cnt == 16'(VSETUP_CYC - 1)) begin
               next_r.pins.highVolt = 1'b0;
               next_r.st = fsp_pkg::ST_DONE;
            end
         end
         fsp_pkg::ST_DONE: begin
            next_r.busy = 1'b0;
            ev[fsp_pkg::IRQ_DONE_BIT] = 1'b1;
            ev[fsp_pkg::IRQ_FAIL_BIT] = r.fail;
            next_r.st = fsp_pkg::ST_IDLE;
         end
         default: next_r.st = fsp_pkg::ST_IDLE;
      endcase
      // ---------------------------------------------------------------
      // register port
      // ---------------------------------------------------------------
      next_r.rdOut = 32'h0;
      if (regRd) begin
         case (regAddr)
            fsp_pkg::REG_CTRL: next_r.rdOut = {28'h0, r.tempExit, r.cmd};
            fsp_pkg::REG_ADDR: next_r.rdOut = {10'h0, r.addr};
            fsp_pkg::REG_DATA: next_r.rdOut = {16'h0, r.wdata};
            fsp_pkg::REG_STATUS: next_r.rdOut = {28'h0, readyBusy, r.timeoutSeen, r.fail, r.busy};
            fsp_pkg::REG_IRQ_STATUS: next_r.rdOut = {30'h0, r.irqStat};
            fsp_pkg::REG_IRQ_MASK: next_r.rdOut = {30'h0, r.irqMask};
            fsp_pkg::REG_RDATA: next_r.rdOut = {16'h0, r.rdata};
            default: next_r.rdOut = 32'h0;
         endcase
      end
      if (regWr) begin
         case (regAddr)
            fsp_pkg::REG_CTRL: begin
               next_r.tempExit = regWdata[fsp_pkg::CTRL_TEMP_EXIT_BIT];
               // a new command is ignored while one runs
               if (!r.busy && regWdata[2:0] != 3'h0) begin
                  next_r.cmd = regWdata[2:0];
                  next_r.busy = 1'b1;
                  next_r.fail = 1'b0;
                  next_r.timeoutSeen = 1'b0;
                  next_r.rdCount = 2'h0;
               end
            end
            fsp_pkg::REG_ADDR: next_r.addr = regWdata[21:0];
            fsp_pkg::REG_DATA: next_r.wdata = regWdata[15:0];
            fsp_pkg::REG_IRQ_MASK: next_r.irqMask = regWdata[1:0];
            default: ;
         endcase
      end
      // set wins over a write-one clear
      if (regWr && regAddr == fsp_pkg::REG_IRQ_STATUS) begin
         next_r.irqStat = (r.irqStat & ~regWdata[1:0]) | ev;
      end else begin
         next_r.irqStat = r.irqStat | ev;
      end
      // new mask takes effect with the same edge as the write, no extra lag
      next_r.irqOut = |(next_r.irqStat & next_r.irqMask);
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         r <= '0;
         r.st <= fsp_pkg::ST_IDLE;
         r.pins.ceN <= 1'b1;
         r.pins.oeN <= 1'b1;
         r.pins.weN <= 1'b1;
         r.pins.rstN <= 1'b1;
         r.irqStat <= fsp_pkg::IRQ_RESET;
      end else begin
         r <= next_r;
      end
   end

   assign flashPins = r.pins;
   assign regRdata = r.rdOut;
   assign irq = r.irqOut;
endmodule : fsp_host

/* tb/fsp_host_assertions.sv */
// port assertions for the flash host controller
`timescale 1ns/10ps
module fsp_host_assertions #(
   parameter int VSETUP_CYC = 4
) (
   // clock, reset, register port
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [31:0] regRdata,
   input wire logic irq,
   // flash side
   input wire fsp_pkg::fsp_pins_s flashPins,
   input wire logic readyBusy
);
   int hvCnt;
   int rbCnt;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // counters of high voltage time, cleared whenever the level drops
   always_ff @(posedge core_clk) begin
      hvCnt <= (flashPins.highVolt && !sys_rst) ? hvCnt + 1 : 0;
      rbCnt <= (flashPins.highVolt && readyBusy && !sys_rst) ? rbCnt + 1 : 0;
   end
   sequence protPulse;
      !flashPins.weN [*3];
   endsequence
   sequence protStart;
      $fell(flashPins.weN) && flashPins.highVolt;
   endsequence
   prot_addr_a: assert property (
      !flashPins.weN && flashPins.highVolt |-> flashPins.addr[1:0] == 2'h2)
      else $error("protect address low bits wrong");
   addr_hold_a: assert property (protStart |-> ##1 $stable(flashPins.addr) [*2])
      else $error("protect address moved in pulse");
   prot_pulse_a: assert property (protStart |-> protPulse)
      else $error("protect pulse too short");
   volt_setup_a: assert property (protStart |-> hvCnt >= VSETUP_CYC)
      else $error("high voltage setup too short");
   // protect pulses drop the level with write enable; only temp exit needs the hold
   volt_hold_a: assert property ($fell(flashPins.highVolt) && $past(flashPins.weN) |-> rbCnt >= VSETUP_CYC)
      else $error("high voltage hold too short");
   rd_strobe_a: assert property (
      $fell(flashPins.oeN) |-> (!flashPins.ceN && !flashPins.oeN) [*3])
      else $error("read strobe too short");
   rdata_idle_a: assert property (!$past(regRd) |-> regRdata == 32'h0)
      else $error("read data outside its cycle");
   irq_sticky_a: assert property (irq && !regWr && !$past(regWr) |=> irq)
      else $error("interrupt dropped without a write");
   reset_idle_a: assert property ($fell(sys_rst) |->
      flashPins.weN && flashPins.oeN && !flashPins.highVolt && !irq)
      else $error("pins not idle after reset");
endmodule : fsp_host_assertions

bind fsp_host fsp_host_assertions #(.VSETUP_CYC(VSETUP_CYC)) chk (.core_clk(core_clk),
   .sys_rst(sys_rst), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
   .flashPins(flashPins), .readyBusy(readyBusy));

/* tb/fsp_flash_model.sv */
// behavioural flash device seen by the host controller
`timescale 1ns/10ps
module fsp_flash_model #(
   parameter int PROG_CYC = 275,
   parameter int ERASE_CYC = 80,
   // arbitrary data word that stands for an erase in this model
   parameter logic [15:0] ERASE_DATA = 16'h00ee
) (
   // clock and host pins
   input wire logic core_clk,
   input wire fsp_pkg::fsp_pins_s flashPins,
   // failMode freezes the operation with the timeout flag up
   input wire logic failMode,
   output logic [15:0] flashDin,
   output logic readyBusy
);
   logic [15:0] mem = 16'h0;
   logic [15:0] last = 16'h0;
   logic [15:0] rdVal;
   logic tog = 1'b0;
   logic prevWe = 1'b1;
   logic prevOe = 1'b1;
   logic prevHv = 1'b0;
   int busy = 0;
   always @(posedge core_clk) begin
      prevWe <= flashPins.weN;
      prevOe <= flashPins.oeN;
      prevHv <= flashPins.highVolt;
      // a protect pulse ends as the level drops, so look at the level before it
      if (!prevWe && flashPins.weN && !prevHv) begin
         mem <= flashPins.dOut;
         busy <= (flashPins.dOut == ERASE_DATA) ? ERASE_CYC : PROG_CYC;
      end else if (busy > 0 && !failMode) begin
         busy <= busy - 1;
      end
      if (prevOe && !flashPins.oeN && busy > 0) begin
         tog <= ~tog;
      end
      if (!flashPins.ceN && !flashPins.oeN) begin
         last <= rdVal;
      end
   end
   // released bus shows the inverse so a stale value never passes
   always_comb begin
      rdVal = (busy > 0) ? {mem[15:8], ~mem[7], tog, failMode, mem[4:0]} : mem;
      flashDin = (flashPins.ceN || flashPins.oeN) ? ~last : rdVal;
   end
   assign readyBusy = (busy == 0);
endmodule : fsp_flash_model

/* tb/test_fsp_host.sv */
// self-checking bench for the flash host controller
`timescale 1ns/10ps
module test_fsp_host;
   localparam int VS = 4;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWdata = 32'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdata;
   logic irq;
   fsp_pkg::fsp_pins_s flashPins;
   logic [15:0] flashDin;
   logic readyBusy;
   logic failMode = 1'b0;
   logic prevOe = 1'b1;
   logic [21:0] protAddr;
   int rdCnt = 0;
   int failures = 0;
   int nTests = 0;
   fsp_host #(.VSETUP_CYC(VS)) dut (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
      .flashPins(flashPins), .flashDin(flashDin), .readyBusy(readyBusy));
   fsp_flash_model #(.PROG_CYC(40)) flash (.core_clk(core_clk), .flashPins(flashPins),
      .failMode(failMode), .flashDin(flashDin), .readyBusy(readyBusy));
   initial begin
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      prevOe <= flashPins.oeN;
      if (prevOe && !flashPins.oeN)
         rdCnt <= rdCnt + 1;
      if (!flashPins.weN && flashPins.highVolt)
         protAddr <= flashPins.addr;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask : rd
   // start a command and poll the busy flag, bounded
   task automatic run(input logic [2:0] cmd, output logic [31:0] st);
      int n;
      n = 0;
      wr(fsp_pkg::REG_CTRL, {29'h0, cmd});
      do begin
         rd(fsp_pkg::REG_STATUS, st);
         n++;
      end while (st[0] !== 1'b0 && n < 500);
      if (st[0] !== 1'b0)
         failures++;
   endtask : run
   task automatic t_poll(input logic fm, input logic [2:0] cmd, input int minRd);
      logic [31:0] v;
      int c0;
      failMode <= fm;
      wr(fsp_pkg::REG_DATA, 32'h5a3c);
      run(fsp_pkg::CMD_WRITE, v);
      wr(fsp_pkg::REG_IRQ_STATUS, 32'h3);
      c0 = rdCnt;
      run(cmd, v);
      check(32'(v[1]), 32'(fm));
      check(32'(rdCnt - c0 >= minRd), 32'h1);
      rd(fsp_pkg::REG_IRQ_STATUS, v);
      check(v, fm ? 32'h3 : 32'h1);
      check(32'(irq), 32'h1);
      wr(fsp_pkg::REG_IRQ_MASK, 32'h0);
      rd(fsp_pkg::REG_STATUS, v);
      check(32'(irq), 32'h0);
      wr(fsp_pkg::REG_IRQ_MASK, 32'h3);
      wr(fsp_pkg::REG_IRQ_STATUS, 32'h3);
      rd(fsp_pkg::REG_STATUS, v);
      check(32'(irq), 32'h0);
      if (!fm) begin
         run(fsp_pkg::CMD_READ, v);
         rd(fsp_pkg::REG_RDATA, v);
         check(v, 32'h5a3c);
      end
      failMode <= 1'b0;
   endtask : t_poll
   task automatic t_prot(input logic [2:0] cmd, input logic [6:0] exp);
      logic [31:0] v;
      wr(fsp_pkg::REG_ADDR, 32'h41);
      run(cmd, v);
      check({25'h0, protAddr[6:0] & 7'h43}, {25'h0, exp});
   endtask : t_prot
   task automatic t_temp;
      int n;
      n = 0;
      wr(fsp_pkg::REG_CTRL, {29'h0, fsp_pkg::CMD_TEMP});
      repeat (2 * VS) @(posedge core_clk);
      check(32'(flashPins.highVolt), 32'h1);
      wr(fsp_pkg::REG_CTRL, 32'h8);
      while (flashPins.highVolt === 1'b1 && n < 100) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      check(32'(flashPins.highVolt), 32'h0);
      check(32'(n >= VS), 32'h1);
      wr(fsp_pkg::REG_CTRL, 32'h0);
   endtask : t_temp
   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", nTests, failures);
      if (failures == 0 && nTests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   initial begin
      logic [31:0] v;
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      #1 check({flashPins.weN, flashPins.highVolt, irq}, 32'h4);
      rd(fsp_pkg::REG_IRQ_STATUS, v);
      check(v, {30'h0, fsp_pkg::IRQ_RESET});
      rd(4'hf, v);
      check(v, 32'h0);
      wr(fsp_pkg::REG_IRQ_MASK, 32'h3);
      t_poll(1'b0, fsp_pkg::CMD_POLL, 2);
      t_poll(1'b0, fsp_pkg::CMD_TOGGLE, 4);
      t_poll(1'b1, fsp_pkg::CMD_POLL, 2);
      t_poll(1'b1, fsp_pkg::CMD_TOGGLE, 3);
      t_prot(fsp_pkg::CMD_PROTECT, 7'h02);
      t_prot(fsp_pkg::CMD_UNPROTECT, 7'h42);
      t_temp;
      give_verdict;
   end
   // cut a hang short well past the expected run length
   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      give_verdict;
   end
endmodule : test_fsp_host
